//--- rtl/fwd_clock_pkg.sv
// Shared constants for the forwarded-clock and output-mode controller.
// Assumes one system clock that ticks twice per converter sampling cycle.
package fwd_clock_pkg;

  // Sample word layout
  localparam int unsigned SAMPLE_W          = 12;
  localparam logic [11:0] SAMPLE_MIDSCALE   = 12'h0800;
  localparam int unsigned LANES             = 4;

  // Output waveform selector codes
  localparam logic [1:0]  MODE_NRZ          = 2'h0;
  localparam logic [1:0]  MODE_NARROW_RTZ   = 2'h1;
  localparam logic [1:0]  MODE_RTZ          = 2'h2;
  localparam logic [1:0]  MODE_RF           = 2'h3;

  // Multiplexer ratio select values
  localparam logic        MUX_4TO1          = 1'b0;
  localparam logic        MUX_2TO1          = 1'b1;

  // Forwarded clock divide select codes; 2 and 3 are illegal
  localparam logic [1:0]  DIV_BY_1          = 2'h0;
  localparam logic [1:0]  DIV_BY_2          = 2'h1;

  // Under-clocking select levels
  localparam logic        UNDERCLOCK_OFF    = 1'b0;
  localparam logic        UNDERCLOCK_ON     = 1'b1;

  // Timing: one system tick is half a sampling cycle
  localparam int unsigned TICKS_PER_SAMPLE  = 2;
  localparam int unsigned PHASE_STEPS       = 8;
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned NARROW_PULSE_PS   = 75;
  localparam int unsigned NARROW_PULSE_RAW  =
    (NARROW_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned NARROW_PULSE_TICKS =
    (NARROW_PULSE_RAW < 1) ? 1 : NARROW_PULSE_RAW;

  // Counter widths and reset values
  localparam int unsigned DIV_CNT_W         = 7;
  localparam int unsigned SLOT_CNT_W        = 5;
  localparam logic [6:0]  DIV_CNT_RESET     = 7'h00;
  localparam logic [4:0]  SLOT_CNT_RESET    = 5'h00;

endpackage

//--- rtl/phase_delay_line.sv
// Tapped delay line for the forwarded clock, one tap per half sample.
// Assumes the select is stable or that a glitch on change is tolerated.
module phase_delay_line #(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_i,
  input  wire logic                     d_i,
  input  wire logic [$clog2(DEPTH)-1:0] sel_i,
  output logic                          q_o
);

  logic [DEPTH-1:0] taps_q;

  initial begin
    // The tap index is $clog2(DEPTH) bits wide, so DEPTH must fill it
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("phase_delay_line: DEPTH must be a power of two, at least 2");
    end
  end

  // Tap 0 is the undelayed input, each further tap adds one tick
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      taps_q <= '0;
    end else begin
      taps_q <= {taps_q[DEPTH-2:0], d_i};
    end
  end

  // Registered tap select keeps the output glitch free
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= (sel_i == '0) ? d_i : taps_q[sel_i - 1'b1];
    end
  end

endmodule

//--- rtl/waveform_shaper.sv
// Output waveform shaping of one sample per sampling cycle.
// Assumes tick_i counts the system ticks inside one sampling cycle.
module waveform_shaper
  import fwd_clock_pkg::*;
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          reset_i,
  input  wire logic [1:0]                    mode_i,
  input  wire logic [fwd_clock_pkg::SAMPLE_W-1:0] sample_i,
  input  wire logic                          tick_i,
  output logic [fwd_clock_pkg::SAMPLE_W-1:0] shaped_o
);

  logic [SAMPLE_W-1:0] shaped_d;
  logic                narrow_zero;

  // Narrow pulse sits at the end of the cycle, fixed in ticks not in rate
  assign narrow_zero = (32'(tick_i) >= (TICKS_PER_SAMPLE - NARROW_PULSE_TICKS));

  always_comb begin
    shaped_d = sample_i;
    case (mode_i)
      MODE_NRZ:        shaped_d = sample_i;
      MODE_NARROW_RTZ: shaped_d = narrow_zero ? SAMPLE_MIDSCALE : sample_i;
      MODE_RTZ:        shaped_d = tick_i ? SAMPLE_MIDSCALE : sample_i;
      MODE_RF:         shaped_d = tick_i ? ~sample_i : sample_i;
      default:         shaped_d = sample_i;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shaped_o <= SAMPLE_MIDSCALE;
    end else begin
      shaped_o <= shaped_d;
    end
  end

endmodule

//--- rtl/fwd_clock_mode_ctrl.sv
// Forwarded data clock, sample pacing and output mode control.
// Assumes clk_sys_i ticks twice per sampling cycle and that the sample
// source launches its words from the forwarded clock it receives.
// Configuration inputs are static straps; a mux, divide or under-clock change restarts pacing.

// Functional notes
// - A two-bit waveform selector picks one of four shapes, code 11 being RF.
// - Without under-clocking in 4:1 a word is taken every four sampling cycles.
// - With under-clocking a word is taken at half that rate, every eight cycles in 4:1.
// - With under-clocking the forwarded clock runs at half its normal frequency.
// - Under-clock select low means inactive and high means active.
// - The under-clock pin defaults to active when left open; ground disables it.
// - The forwarded clock period is twice the mux ratio times the divide factor in samples.
// - A three-bit phase select delays the forwarded clock by up to 3.5 cycles in half steps.
// - Narrow return-to-zero inserts a short fixed-width return pulse each sample; here it is one tick, half the cycle as in RTZ.
// - Return-to-zero holds the sample for half of each sampling cycle.
// - Codes 00, 01 and 10 select NRZ, narrow RTZ and 50 percent RTZ.
// - Mux select 0 is 4:1 and 1 is 2:1, where the third and fourth ports are unused.
// - Divide select 00 gives factor 1, 01 factor 2, and 10 or 11 are not allowed.
// - Each phase select step adds half a cycle; 2:1 uses only the lower four codes.
module fwd_clock_mode_ctrl
  import fwd_clock_pkg::*;
#(
  parameter int unsigned SAMPLE_BITS = 12,
  parameter int unsigned NUM_LANES   = 4
) (
  input  wire logic                                clk_sys_i,
  input  wire logic                                reset_i,
  input  wire logic [1:0]                          output_mode_i,
  input  wire logic                                mux_ratio_select_i,
  input  wire logic [1:0]                          fwd_clock_divide_select_i,
  input  wire logic [2:0]                          fwd_clock_phase_select_i,
  input  wire logic                                underclock_select_i,
  input  wire logic [fwd_clock_pkg::SAMPLE_W-1:0]  port_a_i,
  input  wire logic [fwd_clock_pkg::SAMPLE_W-1:0]  port_b_i,
  input  wire logic [fwd_clock_pkg::SAMPLE_W-1:0]  port_c_i,
  input  wire logic [fwd_clock_pkg::SAMPLE_W-1:0]  port_d_i,
  output logic                                     forwarded_data_clock_o,
  output logic                                     word_take_o,
  output logic [fwd_clock_pkg::SAMPLE_W-1:0]       sample_out_o,
  output logic                                     config_error_o,
  output logic                                     underclock_active_o
);

  import fwd_clock_pkg::*;

  // Elaboration check: the datapath is built for the documented shape
  initial begin
    if (SAMPLE_BITS != SAMPLE_W) $error("fwd_clock_mode_ctrl: SAMPLE_BITS unsupported");
    if (NUM_LANES != LANES) $error("fwd_clock_mode_ctrl: NUM_LANES unsupported");
    // Half-cycle phase steps only exist with two ticks per sample
    if (TICKS_PER_SAMPLE != 2) begin
      $error("fwd_clock_mode_ctrl: TICKS_PER_SAMPLE must be 2");
    end
    // Three select bits address eight taps, no more and no fewer
    if (PHASE_STEPS != 8) begin
      $error("fwd_clock_mode_ctrl: PHASE_STEPS must be 8");
    end
    // Longest forwarded period is 64 ticks, longest word 16 ticks
    if (DIV_CNT_W < 7 || SLOT_CNT_W < 5) begin
      $error("fwd_clock_mode_ctrl: pacing counters too narrow");
    end
    // The return pulse must leave part of the cycle for the sample
    if (NARROW_PULSE_TICKS >= TICKS_PER_SAMPLE) begin
      $error("fwd_clock_mode_ctrl: narrow pulse covers the whole cycle");
    end
  end

  // Forwarded clock period in ticks: 2 ticks x 2N x X x (2 if under-clocked)
  function automatic logic [DIV_CNT_W-1:0] fwd_period_ticks(
    input logic       mux_sel,
    input logic [1:0] div_sel,
    input logic       uc_sel
  );
    logic [DIV_CNT_W-1:0] p;
    p = 7'h10;                                   // 4:1, factor 1, normal
    if (mux_sel == MUX_2TO1) p = p >> 1;
    if (div_sel == DIV_BY_2) p = p << 1;
    if (uc_sel == UNDERCLOCK_ON) p = p << 1;
    return p;
  endfunction

  // Ticks between two word takes: 2 ticks x N x (2 if under-clocked)
  function automatic logic [SLOT_CNT_W-1:0] word_ticks(
    input logic mux_sel,
    input logic uc_sel
  );
    logic [SLOT_CNT_W-1:0] w;
    w = 5'h08;                                   // 4:1 normal, Fs/4
    if (mux_sel == MUX_2TO1) w = w >> 1;
    if (uc_sel == UNDERCLOCK_ON) w = w << 1;
    return w;
  endfunction

  // Lanes c and d carry nothing in 2:1 and are loaded with midscale instead
  function automatic logic [SAMPLE_W-1:0] upper_lane(
    input logic                mux_sel,
    input logic [SAMPLE_W-1:0] port_word
  );
    return (mux_sel == MUX_2TO1) ? SAMPLE_MIDSCALE : port_word;
  endfunction

  // Lane on air: each lane lasts one sample, two when under-clocked
  function automatic logic [1:0] lane_of(
    input logic [SLOT_CNT_W-1:0] slot,
    input logic                  uc_sel
  );
    return (uc_sel == UNDERCLOCK_ON) ? slot[3:2] : slot[2:1];
  endfunction

  // Upper phase codes fold onto the lower four in 2:1
  function automatic logic [2:0] fold_phase(
    input logic       mux_sel,
    input logic [2:0] code
  );
    return (mux_sel == MUX_2TO1) ? {1'b0, code[1:0]} : code;
  endfunction

  // Captured configuration
  logic [1:0]            mode_q;
  logic                  mux_q;
  logic [1:0]            div_q;
  logic [2:0]            phase_q;
  logic                  uc_q;
  logic                  cfg_change;
  logic                  div_legal;
  logic [1:0]            div_eff;

  // Pacing counters
  logic [DIV_CNT_W-1:0]  div_cnt_q;
  logic [DIV_CNT_W-1:0]  period;
  logic [SLOT_CNT_W-1:0] slot_cnt_q;
  logic [SLOT_CNT_W-1:0] slots;
  logic                  last_slot;
  logic                  fwd_raw;
  logic                  capture;
  logic [2:0]            phase_sel;

  // Word and lane selection
  logic [SAMPLE_W-1:0]   word_q [LANES];
  logic [1:0]            lane;
  logic                  tick;
  logic [SAMPLE_W-1:0]   lane_sample;

  // Illegal divide codes fall back to factor 1 and raise the error flag
  assign div_legal = (fwd_clock_divide_select_i == DIV_BY_1) ||
                     (fwd_clock_divide_select_i == DIV_BY_2);
  assign div_eff   = div_legal ? fwd_clock_divide_select_i : DIV_BY_1;

  assign cfg_change = (mux_ratio_select_i != mux_q) || (div_eff != div_q) ||
                      (underclock_select_i != uc_q);

  // Waveform select; the reset value matches an open strap, RF
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_q <= MODE_RF;
    end else begin
      mode_q <= output_mode_i;
    end
  end

  // Multiplexer ratio, re-sampled every tick like all straps
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mux_q <= MUX_4TO1;
    end else begin
      mux_q <= mux_ratio_select_i;
    end
  end

  // Divide factor after illegal codes were folded to factor 1
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      div_q <= DIV_BY_1;
    end else begin
      div_q <= div_eff;
    end
  end

  // Phase select takes effect without restarting the divider
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      phase_q <= 3'h0;
    end else begin
      phase_q <= fwd_clock_phase_select_i;
    end
  end

  // An open pin is pulled high on the board, so only the driven level
  // is seen here; the reset value mirrors that open default
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      uc_q <= UNDERCLOCK_ON;
    end else begin
      uc_q <= underclock_select_i;
    end
  end

  assign period    = fwd_period_ticks(mux_q, div_q, uc_q);
  assign slots     = word_ticks(mux_q, uc_q);
  assign last_slot = (slot_cnt_q == slots - 5'h01);

  // Forwarded clock divider; restarts on any pacing change
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || cfg_change) begin
      div_cnt_q <= DIV_CNT_RESET;
    end else if (div_cnt_q == period - 7'h01) begin
      div_cnt_q <= DIV_CNT_RESET;
    end else begin
      div_cnt_q <= div_cnt_q + 7'h01;
    end
  end

  // High for the first half of the period, square wave; held low in the
  // tick a pacing change restarts the divider, so no stretched first pulse
  assign fwd_raw = !cfg_change && (div_cnt_q < (period >> 1));

  // In 2:1 the upper codes repeat the lower four
  assign phase_sel = fold_phase(mux_q, phase_q);

  // Phase shift in half-cycle ticks on top of the fixed register latency
  phase_delay_line #(
    .DEPTH (PHASE_STEPS)
  ) u_phase_delay (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .d_i       (fwd_raw),
    .sel_i     (phase_sel),
    .q_o       (forwarded_data_clock_o)
  );

  // Slot counter inside one word; lockstep with the divider
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || cfg_change) begin
      slot_cnt_q <= SLOT_CNT_RESET;
    end else if (last_slot) begin
      slot_cnt_q <= SLOT_CNT_RESET;
    end else begin
      slot_cnt_q <= slot_cnt_q + 5'h01;
    end
  end

  // No capture in the tick a pacing change restarts the counters
  assign capture = last_slot && !cfg_change;

  // Word capture on the last slot, so the new word plays from slot 0
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < LANES; i++) begin
        word_q[i] <= SAMPLE_MIDSCALE;
      end
    end else if (capture) begin
      word_q[0] <= port_a_i;
      word_q[1] <= port_b_i;
      word_q[2] <= upper_lane(mux_q, port_c_i);
      word_q[3] <= upper_lane(mux_q, port_d_i);
    end
  end

  // Word take strobe, one tick wide, coincides with the capture edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      word_take_o <= 1'b0;
    end else begin
      word_take_o <= capture;
    end
  end

  // Under-clocking repeats every sample for two sampling cycles
  assign tick = slot_cnt_q[0];
  assign lane = lane_of(slot_cnt_q, uc_q);
  assign lane_sample = word_q[lane];

  // Shaping is independent of mux, divide and phase settings
  waveform_shaper u_shaper (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .mode_i    (mode_q),
    .sample_i  (lane_sample),
    .tick_i    (tick),
    .shaped_o  (sample_out_o)
  );

  // Illegal divide flag, follows the strap one tick later
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      config_error_o <= 1'b0;
    end else begin
      config_error_o <= !div_legal;
    end
  end

  // Under-clock status; reads active out of reset like an open pin
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      underclock_active_o <= 1'b1;
    end else begin
      underclock_active_o <= uc_q;
    end
  end

endmodule

//--- test/fwd_clock_mode_ctrl_checker.sv
// Checker for word pacing, forwarded clock rate and output shaping.
// Assumes configuration inputs only change while reset is held.
module fwd_clock_mode_ctrl_checker
  import fwd_clock_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [1:0]  output_mode_i,
  input wire logic        mux_ratio_select_i,
  input wire logic [1:0]  fwd_clock_divide_select_i,
  input wire logic        underclock_select_i,
  input wire logic [11:0] port_a_i,
  input wire logic [11:0] port_b_i,
  input wire logic        forwarded_data_clock_o,
  input wire logic        word_take_o,
  input wire logic [11:0] sample_out_o,
  input wire logic        config_error_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Short aliases keep the properties on few lines
  wire       t  = word_take_o;
  wire       f  = forwarded_data_clock_o;
  wire       uc = underclock_select_i;
  wire       mx = mux_ratio_select_i;
  wire [1:0] dv = fwd_clock_divide_select_i;
  wire [1:0] md = output_mode_i;
  wire [11:0] a = port_a_i;
  wire [11:0] s = sample_out_o;

  // Pacing: spacing to the next word; only plain 4:1 also bars an extra pulse in between
  word_gap_a: assert property (t && !mx && !uc |-> ##1 !t [*7] ##1 t)
    else $error("word spacing wrong in 4:1");
  uc_word_gap_a: assert property (t && !mx && uc |-> ##16 t)
    else $error("word spacing wrong when under-clocked");
  half_mux_gap_a: assert property (t && mx && !uc |-> ##4 t)
    else $error("word spacing wrong in 2:1");
  // Forwarded clock: square wave, period scales with factor and under-clock
  fwd_square_a: assert property ($rose(f) && !mx && dv == 2'h0 && !uc
    |-> f [*8] ##1 !f [*8] ##1 f) else $error("forwarded clock shape wrong");
  fwd_div_a: assert property ($rose(f) && !mx && dv == 2'h1 && !uc
    |-> ##32 $rose(f)) else $error("divided clock period wrong");
  fwd_uc_a: assert property ($rose(f) && !mx && dv == 2'h0 && uc
    |-> ##32 $rose(f)) else $error("under-clocked clock period wrong");
  cfg_err_a: assert property (config_error_o |-> dv[1])
    else $error("config error without illegal divide code");
  cfg_err_set_a: assert property (dv[1] |-> ##[0:2] config_error_o)
    else $error("illegal divide code not flagged");
  // Shaping of the first lane of each word, second half by mode
  nrz_shape_a: assert property (t && md == MODE_NRZ && !uc |-> ##1 s == $past(a, 2)
    ##1 s == $past(a, 3) ##1 s == $past(port_b_i, 4)) else $error("NRZ stream wrong");
  narrow_shape_a: assert property (t && md == MODE_NARROW_RTZ |-> ##1 s == $past(a, 2)
    ##1 s == SAMPLE_MIDSCALE) else $error("narrow return pulse wrong");
  rtz_shape_a: assert property (t && md == MODE_RTZ |-> ##1 s == $past(a, 2)
    ##1 s == SAMPLE_MIDSCALE) else $error("return-to-zero half wrong");
  rf_shape_a: assert property (t && md == MODE_RF |-> ##1 s == $past(a, 2)
    ##1 s == ~$past(a, 3)) else $error("RF mirrored half wrong");

  // Main scenarios reached
  uc_word_c: cover property (t && uc);
  div_clock_c: cover property ($rose(f) && dv == 2'h1);
  rf_word_c: cover property (t && md == MODE_RF);
endmodule

//--- test/sample_source_model.sv
// Sample source on the far side: launches one word per pacing pulse.
// Assumes the controller captures the lanes on the edge before the pulse.
module sample_source_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        word_take_i,
  output logic      [11:0] port_a_o,
  output logic      [11:0] port_b_o,
  output logic      [11:0] port_c_o,
  output logic      [11:0] port_d_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] seq_q = 8'h00;

  // New word only after the old one was taken, changed half a tick away
  // from the capture edge so the lanes never move while sampled
  always @(negedge clk_sys_i) begin
    if (reset_i) begin
      seq_q <= 8'h00;
    end else if (word_take_i === 1'b1) begin
      seq_q <= seq_q + 8'h01;
    end
  end
  // Lane tags keep lanes apart from midscale and from their own inverse
  assign port_a_o = {4'h1, seq_q};
  assign port_b_o = {4'h2, seq_q};
  assign port_c_o = {4'h4, seq_q};
  assign port_d_o = {4'hC, seq_q};
endmodule

//--- test/tb_fwd_clock_mode_ctrl.sv
// Bench for the forwarded clock and output mode controller.
// Assumes configuration straps are applied only while reset is held.
module tb_fwd_clock_mode_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [1:0]  output_mode_i = 2'h0;
  logic        mux_ratio_select_i = 1'b0;
  logic [1:0]  fwd_clock_divide_select_i = 2'h0;
  logic [2:0]  fwd_clock_phase_select_i = 3'h0;
  logic        underclock_select_i = 1'b1;
  logic [11:0] port_a_i, port_b_i, port_c_i, port_d_i, sample_out_o;
  logic        forwarded_data_clock_o, word_take_o, config_error_o, underclock_active_o;
  int          error_cnt = 0;
  int          checks = 0;
  // Settings {mux, divide, under-clock}, illegal divide codes last
  logic [3:0]  tbl [7] = '{4'h0, 4'h2, 4'h1, 4'h8, 4'hB, 4'h4, 4'h7};

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  fwd_clock_mode_ctrl DUT (.clk_sys_i, .reset_i, .output_mode_i, .mux_ratio_select_i,
    .fwd_clock_divide_select_i, .fwd_clock_phase_select_i, .underclock_select_i,
    .port_a_i, .port_b_i, .port_c_i, .port_d_i, .forwarded_data_clock_o, .word_take_o,
    .sample_out_o, .config_error_o, .underclock_active_o);
  sample_source_model src (.clk_sys_i, .reset_i, .word_take_i(word_take_o),
    .port_a_o(port_a_i), .port_b_o(port_b_i), .port_c_o(port_c_i), .port_d_o(port_d_i));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Straps change only under reset, so both counters restart cleanly
  task automatic cfg(input logic [1:0] md, input logic mx, input logic [1:0] dv,
                     input logic [2:0] ps, input logic uc);
    @(negedge clk_sys_i);
    reset_i = 1'b1;
    {output_mode_i, mux_ratio_select_i} = {md, mx};
    {fwd_clock_divide_select_i, fwd_clock_phase_select_i, underclock_select_i} = {dv, ps, uc};
    repeat (4) @(negedge clk_sys_i);
    reset_i = 1'b0;
  endtask

  // Ticks until the next rising edge of the pacing pulse or the clock
  task automatic edge_of(input bit f, output int n);
    logic p, c;
    p = 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge clk_sys_i);
      #1;
      c = f ? forwarded_data_clock_o : word_take_o;
      if (c === 1'b1 && p === 1'b0) break;
      p = c;
    end
  endtask

  task automatic period(input bit f, output int n);
    edge_of(f, n);
    edge_of(f, n);
    n = n + 1;
  endtask

  initial begin
    int n, w, x, base;
    logic [3:0] c;
    repeat (2) @(negedge clk_sys_i);
    check("uc_reset", underclock_active_o, 16'h0001);
    // Rates for the seven table settings; modes cycle so each shape is seen
    for (int k = 0; k < 7; k++) begin
      c = tbl[k];
      cfg(k[1:0], c[3], c[2:1], 3'h0, c[0]);
      w = (c[3] ? 2 : 4) * (c[0] ? 2 : 1) * 2;
      x = (c[2:1] == 2'h1) ? 2 : 1;
      period(1'b0, n);
      check("word_period", n, w);
      period(1'b1, n);
      check("fwd_period", n, 2 * w * x);
      check("uc_active", underclock_active_o, c[0]);
      check("cfg_error", config_error_o, c[2]);
    end
    // Half-sample steps; upper codes fold onto the lower four in 2:1
    for (int m = 0; m < 2; m++) begin
      for (int p = 0; p < 8; p++) begin
        cfg(2'h0, m[0], 2'h0, p[2:0], 1'b0);
        edge_of(1'b1, n);
        if (p == 0) base = n;
        check("phase_delay", n - base, m ? p % 4 : p);
      end
    end
    summarize();
  end

  // Hang guard, far beyond the several hundred ticks the tests need
  initial begin
    #50us;
    error_cnt++;
    summarize();
  end
endmodule

bind fwd_clock_mode_ctrl fwd_clock_mode_ctrl_checker chk (.clk_sys_i, .reset_i,
  .output_mode_i, .mux_ratio_select_i, .fwd_clock_divide_select_i, .underclock_select_i,
  .port_a_i, .port_b_i, .forwarded_data_clock_o, .word_take_o, .sample_out_o,
  .config_error_o);
